// ==== sqr_pkg.sv ====
// shared constants, field layout and helpers for the sample sequencer
package sqr_pkg;
  localparam int SQR_NUM_SEQ  = 4;
  localparam int SQR_NUM_STEP = 17;
  localparam int SQR_DATA_W   = 12;
  localparam int SQR_ACC_W    = 18;
  localparam int SQR_CNT_W    = 4;
  localparam int SQR_ADDR_W   = 12;
  // register byte offsets
  localparam logic [11:0] SQR_OFF_CTRL   = 12'h000;
  localparam logic [11:0] SQR_OFF_TRIG   = 12'h004;
  localparam logic [11:0] SQR_OFF_PTRIG  = 12'h008;
  localparam logic [11:0] SQR_OFF_FLAGS  = 12'h00c;
  localparam logic [11:0] SQR_OFF_STATUS = 12'h010;
  localparam logic [11:0] SQR_OFF_FIFO   = 12'h020;
  localparam logic [11:0] SQR_OFF_COUNT  = 12'h030;
  localparam logic [11:0] SQR_OFF_STEP   = 12'h040;
  // field positions
  localparam int SQR_CTRL_AVG_LSB  = 4;
  localparam int SQR_TRIG_PRIO_LSB = 8;
  localparam int SQR_FLAGS_UNF_LSB = 4;
  localparam int SQR_STEP_DIFF_BIT = 3;
  localparam int SQR_STEP_TEMP_BIT = 4;
  localparam int SQR_STEP_LAST_BIT = 5;
  localparam int SQR_STEP_IRQ_BIT  = 6;
  localparam int SQR_STEP_W        = 7;
  // reset values and limits
  localparam logic [3:0]  SQR_EN_RST   = 4'h0;
  localparam logic [2:0]  SQR_AVG_RST  = 3'h0;
  localparam logic [2:0]  SQR_AVG_MAX  = 3'h6;
  localparam logic [31:0] SQR_TRIG_RST = 32'h0000e400;
  // trigger source codes
  localparam logic [1:0] SQR_SRC_PROC   = 2'h0;
  localparam logic [1:0] SQR_SRC_EXT    = 2'h1;
  localparam logic [1:0] SQR_SRC_TIMER  = 2'h2;
  localparam logic [1:0] SQR_SRC_ALWAYS = 2'h3;

  function automatic logic [3:0] sqr_seq_len(input int s);
    case (s)
      0:       sqr_seq_len = 4'h8;
      1, 2:    sqr_seq_len = 4'h4;
      default: sqr_seq_len = 4'h1;
    endcase
  endfunction

  function automatic logic [4:0] sqr_step_base(input logic [1:0] s);
    case (s)
      2'h0:    sqr_step_base = 5'h00;
      2'h1:    sqr_step_base = 5'h08;
      2'h2:    sqr_step_base = 5'h0c;
      default: sqr_step_base = 5'h10;
    endcase
  endfunction
endpackage

// ==== sqr_fifo_if.sv ====
// carrier between the sequencer core and one result fifo
`timescale 1ns/10ps
`default_nettype none
interface sqr_fifo_if #(parameter int DW = 12, parameter int CW = 4);
  logic          push;
  logic [DW-1:0] push_data;
  logic          pop;
  logic [DW-1:0] rd_data;
  logic [CW-1:0] count;
  modport ctl   (output push, push_data, pop, input rd_data, count);
  modport store (input push, push_data, pop, output rd_data, count);
endinterface
`default_nettype wire

// ==== sqr_fifo.sv ====
// per-sequence result fifo
`timescale 1ns/10ps
`default_nettype none
module sqr_fifo #(
  parameter int DEPTH = 8,
  parameter int DW    = 12,
  parameter int CW    = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core side
  sqr_fifo_if.store f
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [PW-1:0]            wr;
    logic [PW-1:0]            rd;
    logic [CW-1:0]            cnt;
  } sqr_fifo_s;

  sqr_fifo_s q_ff, nxt_q;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    logic do_push;
    logic do_pop;
    nxt_q   = q_ff;
    do_pop  = f.pop && (q_ff.cnt != '0);
    // a full fifo drops the new result; overflow is flagged upstream
    do_push = f.push && (q_ff.cnt != CW'(DEPTH));
    if (do_push) begin
      nxt_q.mem[q_ff.wr] = f.push_data;
      nxt_q.wr           = inc(q_ff.wr);
    end
    if (do_pop) begin
      nxt_q.rd = inc(q_ff.rd);
    end
    nxt_q.cnt = q_ff.cnt + CW'(do_push) - CW'(do_pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign f.rd_data = q_ff.mem[q_ff.rd];
  assign f.count   = q_ff.cnt;
endmodule
`default_nettype wire

// ==== sqr_arb.sv ====
// fixed-priority pick among pending sequences
`timescale 1ns/10ps
`default_nettype none
module sqr_arb (
  // requests
  input  wire logic [3:0]      pending,
  input  wire logic [3:0][1:0] prio,
  // grant
  output logic                 grant_vld,
  output logic [1:0]           grant_seq
);
  always_comb begin
    logic [1:0] best;
    best      = 2'h3;
    grant_vld = 1'b0;
    grant_seq = 2'h0;
    // lowest value wins; ties go to the lower sequence number
    for (int s = 0; s < 4; s++) begin
      if (pending[s] && (!grant_vld || prio[s] < best)) begin
        grant_vld = 1'b1;
        grant_seq = 2'(s);
        best      = prio[s];
      end
    end
  end
endmodule
`default_nettype wire

// ==== sqr_top.sv ====
// sample sequencer: apb registers, triggers, arbitration, stepping, averaging
// What this block does
// RULE_01 - four sequences of eight, four, four, one
// RULE_02 - per-sequence trigger source; software command trigger
// RULE_03 - external pin event starts sequence
// RULE_04 - timer trigger output starts sequence
// RULE_05 - always trigger repeats, below higher priorities
// RULE_06 - two-bit priority, zero is highest
// RULE_07 - software keeps priorities unique
// RULE_08 - per-sequence fifo with readable sample count
// RULE_09 - disabled sequence ignores triggers
// RULE_10 - software configures before enabling
// RULE_11 - overflow when trigger finds unread samples
// RULE_12 - overflow sticky until software clears
// RULE_13 - underflow when reading an empty fifo
// RULE_14 - step holds channel, temp, diff, last, irq
// RULE_15 - last marker stops; irq flag pulses
// RULE_16 - steps run in ascending index order
// RULE_17 - differential select names a channel pair
// RULE_18 - software avoids differential with temp sensor
// RULE_19 - highest priority triggered sequence runs first
// RULE_20 - underflow sticky until software clears
// RULE_21 - one shared averaging factor, averaged entries
// RULE_22 - fifo holds at least a full sequence
`timescale 1ns/10ps
`default_nettype none
module sqr_top (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sqr_pkg::SQR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // trigger sources
  input  wire logic                        ext_trig_pin,
  input  wire logic                        timer_trig,
  // conversion core
  output logic                             conv_req,
  output logic      [2:0]                  conv_chan,
  output logic                             conv_diff,
  output logic                             conv_temp,
  input  wire logic                        conv_done,
  input  wire logic [sqr_pkg::SQR_DATA_W-1:0] conv_data,
  // per-step completion events
  output logic      [3:0]                  seq_step_irq
);
  import sqr_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_GAP} sqr_st_e;

  typedef struct packed {
    sqr_st_e                                st;
    logic [1:0]                             seq;
    logic [2:0]                             step;
    logic [5:0]                             avg_cnt;
    logic [SQR_ACC_W-1:0]                   acc;
    logic [3:0]                             en;
    logic [2:0]                             avg;
    logic [3:0][1:0]                        src;
    logic [3:0][1:0]                        prio;
    logic [SQR_NUM_STEP-1:0][SQR_STEP_W-1:0] steps;
    logic [3:0]                             pend;
    logic [3:0]                             ovf;
    logic [3:0]                             unf;
    logic [3:0]                             irq;
    logic [31:0]                            rdata;
    logic                                   slverr;
    logic [1:0]                             ext_sync;
    logic                                   ext_prev;
  } sqr_top_s;

  sqr_top_s q_ff, nxt_q;

  logic [3:0]                 push_vec;
  logic [3:0]                 pop_vec;
  logic [SQR_DATA_W-1:0]      push_val;
  logic [3:0][SQR_DATA_W-1:0] fifo_rd;
  logic [3:0][SQR_CNT_W-1:0]  fifo_cnt;
  logic                       grant_vld;
  logic [1:0]                 grant_seq;

  ////////////////////////////////////////////////////////////////////////////
  // result fifos, sized to the longest run of each sequence

  sqr_fifo_if #(.DW(SQR_DATA_W), .CW(SQR_CNT_W)) fif [SQR_NUM_SEQ] ();

  for (genvar g = 0; g < SQR_NUM_SEQ; g++) begin : g_fifo
    assign fif[g].push      = push_vec[g];
    assign fif[g].push_data = push_val;
    assign fif[g].pop       = pop_vec[g];
    assign fifo_rd[g]       = fif[g].rd_data;
    assign fifo_cnt[g]      = fif[g].count;
    sqr_fifo #(
      .DEPTH (int'(sqr_seq_len(g))), // RULE_22 RULE_01
      .DW    (SQR_DATA_W),
      .CW    (SQR_CNT_W)
    ) u_fifo (
      .pclk    (pclk),
      .presetn (presetn),
      .f       (fif[g])
    );
  end

  sqr_arb u_arb (
    .pending   (q_ff.pend),
    .prio      (q_ff.prio),
    .grant_vld (grant_vld),
    .grant_seq (grant_seq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers

  function automatic logic is_step(input logic [SQR_ADDR_W-1:0] a);
    is_step = (a >= SQR_OFF_STEP) && (a < SQR_OFF_STEP + 12'(4 * SQR_NUM_STEP));
  endfunction

  function automatic logic [4:0] step_idx(input logic [SQR_ADDR_W-1:0] a);
    logic [SQR_ADDR_W-1:0] d;
    d        = a - SQR_OFF_STEP;
    step_idx = d[6:2];
  endfunction

  function automatic logic in_bank(input logic [SQR_ADDR_W-1:0] a,
                                   input logic [SQR_ADDR_W-1:0] base);
    in_bank = (a[SQR_ADDR_W-1:4] == base[SQR_ADDR_W-1:4]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic                  setup;
    logic                  wr_acc;
    logic                  ext_edge;
    logic [3:0]            ptrig;
    logic [3:0]            trig;
    logic [6:0]            cfg;
    logic [SQR_ACC_W-1:0]  sum;
    logic [1:0]            bs;
    nxt_q    = q_ff;
    push_vec = 4'h0;
    pop_vec  = 4'h0;
    push_val = '0;
    ptrig    = 4'h0;
    sum      = '0;
    trig     = 4'h0;
    cfg      = '0;
    nxt_q.irq = 4'h0;
    setup    = psel && !penable;
    wr_acc   = psel && penable && pwrite;
    bs       = paddr[3:2];

    // two-stage pin synchroniser, edge taken behind the second stage
    nxt_q.ext_sync = {q_ff.ext_sync[0], ext_trig_pin};
    nxt_q.ext_prev = q_ff.ext_sync[1];
    ext_edge       = q_ff.ext_sync[1] && !q_ff.ext_prev; // RULE_03

    // reads are decoded in the setup cycle so a pop happens exactly once
    if (setup) begin
      nxt_q.rdata  = 32'h0;
      nxt_q.slverr = 1'b0;
      if (paddr[1:0] != 2'h0) begin
        nxt_q.slverr = 1'b1;
      end else if (paddr == SQR_OFF_CTRL) begin
        nxt_q.rdata = {25'h0, q_ff.avg, q_ff.en};
      end else if (paddr == SQR_OFF_TRIG) begin
        nxt_q.rdata = {16'h0, q_ff.prio, q_ff.src};
      end else if (paddr == SQR_OFF_PTRIG) begin
        nxt_q.rdata = 32'h0;
      end else if (paddr == SQR_OFF_FLAGS) begin
        nxt_q.rdata = {24'h0, q_ff.unf, q_ff.ovf};
      end else if (paddr == SQR_OFF_STATUS) begin
        nxt_q.rdata = {26'h0, q_ff.step, q_ff.seq, q_ff.st != ST_IDLE};
      end else if (in_bank(paddr, SQR_OFF_FIFO)) begin
        if (!pwrite) begin
          nxt_q.rdata = {20'h0, fifo_rd[bs]};
          pop_vec[bs] = 1'b1;
          if (fifo_cnt[bs] == '0) begin
            nxt_q.rdata = 32'h0;
            nxt_q.unf[bs] = 1'b1; // RULE_13 RULE_20
          end
        end
      end else if (in_bank(paddr, SQR_OFF_COUNT)) begin
        nxt_q.rdata = {28'h0, fifo_cnt[bs]}; // RULE_08
      end else if (is_step(paddr)) begin
        nxt_q.rdata = {25'h0, q_ff.steps[step_idx(paddr)]};
      end else begin
        nxt_q.slverr = 1'b1;
      end
    end

    // writes take effect at the access edge
    if (wr_acc && paddr[1:0] == 2'h0) begin
      if (paddr == SQR_OFF_CTRL) begin
        nxt_q.en  = pwdata[3:0];
        nxt_q.avg = (pwdata[SQR_CTRL_AVG_LSB +: 3] > SQR_AVG_MAX) ?
                    SQR_AVG_MAX : pwdata[SQR_CTRL_AVG_LSB +: 3]; // RULE_21
      end else if (paddr == SQR_OFF_TRIG) begin
        for (int s = 0; s < 4; s++) begin
          nxt_q.src[s]  = pwdata[2*s +: 2];
          nxt_q.prio[s] = pwdata[SQR_TRIG_PRIO_LSB + 2*s +: 2]; // RULE_06
        end
      end else if (paddr == SQR_OFF_PTRIG) begin
        ptrig = pwdata[3:0]; // RULE_02
      end else if (paddr == SQR_OFF_FLAGS) begin
        // clears first; hardware sets below win in the same cycle
        nxt_q.ovf = nxt_q.ovf & ~pwdata[3:0]; // RULE_12
        nxt_q.unf = nxt_q.unf & ~pwdata[SQR_FLAGS_UNF_LSB +: 4]; // RULE_20
      end else if (is_step(paddr)) begin
        nxt_q.steps[step_idx(paddr)] = pwdata[SQR_STEP_W-1:0]; // RULE_14
      end
    end

    // trigger capture per sequence
    for (int s = 0; s < 4; s++) begin
      unique case (q_ff.src[s])
        SQR_SRC_PROC:  trig[s] = ptrig[s]; // RULE_02
        SQR_SRC_EXT:   trig[s] = ext_edge; // RULE_03
        SQR_SRC_TIMER: trig[s] = timer_trig; // RULE_04
        SQR_SRC_ALWAYS: trig[s] = 1'b1; // RULE_05
      endcase
      if (!q_ff.en[s]) begin
        nxt_q.pend[s] = 1'b0; // RULE_09
      end else if (trig[s] && !q_ff.pend[s] &&
                   !(q_ff.st != ST_IDLE && q_ff.seq == 2'(s))) begin
        nxt_q.pend[s] = 1'b1; // RULE_09
        if (fifo_cnt[s] != '0) begin
          nxt_q.ovf[s] = 1'b1; // RULE_11 RULE_12
        end
      end
    end

    // stepping through the granted sequence
    cfg = q_ff.steps[sqr_step_base(q_ff.seq) + 5'(q_ff.step)];
    unique case (q_ff.st)
      ST_IDLE: begin
        if (grant_vld) begin
          nxt_q.seq     = grant_seq; // RULE_19 RULE_05
          nxt_q.step    = 3'h0;
          nxt_q.avg_cnt = 6'h0;
          nxt_q.acc     = '0;
          nxt_q.pend[grant_seq] = 1'b0;
          nxt_q.st      = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          sum       = q_ff.acc + SQR_ACC_W'(conv_data);
          nxt_q.acc = sum;
          nxt_q.st  = ST_GAP;
          nxt_q.avg_cnt = q_ff.avg_cnt + 6'h1;
          // averaging: 2^avg conversions per step, one averaged entry
          if (q_ff.avg_cnt == 6'((7'h1 << q_ff.avg) - 7'h1)) begin // RULE_21
            push_val          = SQR_DATA_W'(sum >> q_ff.avg);
            push_vec[q_ff.seq] = 1'b1; // RULE_08
            nxt_q.avg_cnt     = 6'h0;
            nxt_q.acc         = '0;
            nxt_q.irq[q_ff.seq] = cfg[SQR_STEP_IRQ_BIT]; // RULE_15
            if (cfg[SQR_STEP_LAST_BIT] ||
                4'(q_ff.step) == sqr_seq_len(int'(q_ff.seq)) - 4'h1) begin
              nxt_q.st = ST_IDLE; // RULE_15 RULE_16
            end else begin
              nxt_q.step = q_ff.step + 3'h1; // RULE_16
            end
          end
        end
      end
      ST_GAP: begin
        nxt_q.st = ST_CONV;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff      <= '0;
      q_ff.st   <= ST_IDLE;
      q_ff.en   <= SQR_EN_RST;
      q_ff.avg  <= SQR_AVG_RST;
      q_ff.src  <= SQR_TRIG_RST[7:0];
      q_ff.prio <= SQR_TRIG_RST[15:8];
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  logic [SQR_STEP_W-1:0] cur_cfg;
  assign cur_cfg = q_ff.steps[sqr_step_base(q_ff.seq) + 5'(q_ff.step)];

  // no validity check: bad pair or temp+diff is passed through as written
  assign conv_req     = (q_ff.st == ST_CONV);
  assign conv_chan    = cur_cfg[2:0]; // RULE_17
  assign conv_diff    = cur_cfg[SQR_STEP_DIFF_BIT]; // RULE_17
  assign conv_temp    = cur_cfg[SQR_STEP_TEMP_BIT]; // RULE_14
  assign seq_step_irq = q_ff.irq; // RULE_15
  assign prdata       = q_ff.rdata;
  assign pslverr      = q_ff.slverr;
  assign pready       = 1'b1;
endmodule
`default_nettype wire

// ==== sqr_top_asserts.sv ====
// port checker for the sample sequencer
`timescale 1ns/10ps
`default_nettype none
module sqr_top_asserts (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // triggers and core
  input wire logic        ext_trig_pin,
  input wire logic        timer_trig,
  input wire logic        conv_req,
  input wire logic [2:0]  conv_chan,
  input wire logic        conv_diff,
  input wire logic        conv_temp,
  input wire logic        conv_done,
  input wire logic [11:0] conv_data,
  input wire logic [3:0]  seq_step_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_done_drops_req: assert property (conv_req && conv_done |=> !conv_req)
    else $error("request still high after done");
  a_select_held: assert property (conv_req && !conv_done |=> conv_req && $stable({conv_chan, conv_diff, conv_temp}))
    else $error("step select moved during conversion");
  a_irq_after_step: assert property (seq_step_irq != 4'h0 |-> $past(conv_req && conv_done))
    else $error("step event without a finished conversion");
  a_irq_one_seq: assert property ($onehot0(seq_step_irq))
    else $error("two sequences signalled at once");
  a_irq_single: assert property (seq_step_irq != 4'h0 |=> seq_step_irq == 4'h0)
    else $error("step event longer than one cycle");
  a_ready_always: assert property (pready)
    else $error("bus wait state seen");
  a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_read_at_setup: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
    else $error("read result moved outside setup");
  c_irq: cover property (seq_step_irq[0]);
  c_err: cover property (pslverr);
  c_diff: cover property (conv_req && conv_diff);
  c_temp: cover property (conv_req && conv_temp);
endmodule
bind sqr_top sqr_top_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_trig_pin(ext_trig_pin), .timer_trig(timer_trig),
  .conv_req(conv_req), .conv_chan(conv_chan), .conv_diff(conv_diff), .conv_temp(conv_temp),
  .conv_done(conv_done), .conv_data(conv_data), .seq_step_irq(seq_step_irq));
`default_nettype wire

// ==== sqr_core_model.sv ====
// behavioural conversion core with adjustable answer delay
`timescale 1ns/10ps
`default_nettype none
module sqr_core_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // sequencer side
  input  wire logic        conv_req,
  input  wire logic [2:0]  conv_chan,
  input  wire logic        conv_diff,
  input  wire logic        conv_temp,
  output logic             conv_done,
  output logic      [11:0] conv_data,
  // answer delay in cycles
  input  wire logic [3:0]  lat
);
  logic [3:0] wait_cnt;
  logic [4:0] n_conv;
  logic [2:0] chan_log [0:31];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 12'h0;
      n_conv <= 5'h0;
    end else begin
      conv_done <= 1'b0;
      // data only meaningful with done; scramble it otherwise
      conv_data <= ~conv_data;
      if (conv_req && !conv_done) begin
        if (wait_cnt >= lat) begin
          conv_done <= 1'b1;
          conv_data <= {6'h2a, conv_temp, conv_diff, 1'b0, conv_chan};
          chan_log[n_conv] <= conv_chan;
          n_conv <= n_conv + 5'h1;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// bench for the sample sequencer with a behavioural core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sqr_pkg::*;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } sqr_row_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        ext_trig_pin, timer_trig, conv_req, conv_diff, conv_temp, conv_done;
  logic [11:0] paddr, conv_data;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  conv_chan;
  logic [3:0]  seq_step_irq, lat;
  logic [4:0]  k;
  int          mismatches, checks_done, irq0_cnt, i0;
  sqr_row_s    rows [0:10] = '{
    '{1'b0, SQR_OFF_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, SQR_OFF_TRIG, 32'h0, SQR_TRIG_RST, 1'b0},
    '{1'b0, SQR_OFF_FLAGS, 32'h0, 32'h0, 1'b0},
    '{1'b1, SQR_OFF_CTRL, 32'h70, 32'h0, 1'b0},
    '{1'b0, SQR_OFF_CTRL, 32'h0, 32'h60, 1'b0},
    '{1'b1, SQR_OFF_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h080, 32'h7f, 32'h0, 1'b0},
    '{1'b0, 12'h080, 32'h0, 32'h7f, 1'b0},
    '{1'b0, 12'h014, 32'h0, 32'h0, 1'b1},
    '{1'b0, 12'h002, 32'h0, 32'h0, 1'b1},
    '{1'b0, SQR_OFF_PTRIG, 32'h0, 32'h0, 1'b0}};
  sqr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trig_pin(ext_trig_pin), .timer_trig(timer_trig),
    .conv_req(conv_req), .conv_chan(conv_chan), .conv_diff(conv_diff),
    .conv_temp(conv_temp), .conv_done(conv_done), .conv_data(conv_data),
    .seq_step_irq(seq_step_irq));
  sqr_core_model i_core (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
    .conv_chan(conv_chan), .conv_diff(conv_diff), .conv_temp(conv_temp),
    .conv_done(conv_done), .conv_data(conv_data), .lat(lat));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (seq_step_irq[0] === 1'b1) irq0_cnt <= irq0_cnt + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkc(input logic [2:0] got, input logic [2:0] exp);
    chk({29'h0, got}, {29'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rd, x);
  endtask
  // waits for the core to have answered t conversions in total
  task automatic wait_conv(input logic [4:0] t);
    int n;
    n = 0;
    while (i_core.n_conv !== t && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500) begin
      mismatches++;
      give_verdict();
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic timer_pulse;
    @(posedge pclk);
    timer_trig <= 1'b1;
    @(posedge pclk);
    timer_trig <= 1'b0;
  endtask
  function automatic logic [31:0] res(input logic [2:0] c, input logic d);
    res = {20'h0, 6'h2a, 1'b0, d, 1'b0, c};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, ext_trig_pin, timer_trig} = 6'h0;
    {paddr, pwdata, lat} = 48'h0;
    mismatches = 0;
    checks_done = 0;
    irq0_cnt = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].x);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    wr(SQR_OFF_STEP, 32'h45);
    wr(SQR_OFF_STEP + 12'h4, 32'h08);
    wr(SQR_OFF_STEP + 12'h8, 32'h67);
    wr(SQR_OFF_STEP + 12'hc, 32'h01);
    wr(SQR_OFF_CTRL, 32'h1);
    k = i_core.n_conv;
    i0 = irq0_cnt;
    wr(SQR_OFF_PTRIG, 32'h1);
    wait_conv(k + 5'h3);
    chkc(i_core.chan_log[k], 3'h5);
    chkc(i_core.chan_log[k + 5'h1], 3'h0);
    chkc(i_core.chan_log[k + 5'h2], 3'h7);
    chk(32'(irq0_cnt - i0), 32'h2);
    rdc(SQR_OFF_COUNT, 32'h3);
    rdc(SQR_OFF_FIFO, res(3'h5, 1'b0));
    rdc(SQR_OFF_FIFO, res(3'h0, 1'b1));
    rdc(SQR_OFF_FIFO, res(3'h7, 1'b0));
    rdc(SQR_OFF_FIFO, 32'h0);
    rdc(SQR_OFF_FLAGS, 32'h10);
    rdc(SQR_OFF_FIFO, 32'h0);
    rdc(SQR_OFF_FLAGS, 32'h10);
    wr(SQR_OFF_FLAGS, 32'h10);
    rdc(SQR_OFF_FLAGS, 32'h0);
    k = i_core.n_conv;
    wr(SQR_OFF_PTRIG, 32'h1);
    wait_conv(k + 5'h3);
    wr(SQR_OFF_PTRIG, 32'h1);
    wait_conv(k + 5'h6);
    wr(SQR_OFF_PTRIG, 32'h1);
    wait_conv(k + 5'h9);
    rdc(SQR_OFF_FLAGS, 32'h1);
    wr(SQR_OFF_FLAGS, 32'h1);
    rdc(SQR_OFF_FLAGS, 32'h0);
    k = i_core.n_conv;
    wr(SQR_OFF_PTRIG, 32'h2);
    repeat (20) @(posedge pclk);
    chk({27'h0, i_core.n_conv}, {27'h0, k});
    wr(SQR_OFF_CTRL, 32'h0);
    wr(SQR_OFF_TRIG, 32'hc668);
    wr(SQR_OFF_STEP + 12'h20, 32'h21);
    wr(SQR_OFF_STEP + 12'h30, 32'h22);
    wr(SQR_OFF_STEP + 12'h40, 32'h33);
    wr(SQR_OFF_CTRL, 32'he);
    lat <= 4'h9;
    k = i_core.n_conv;
    timer_pulse();
    wait_conv(k + 5'h2);
    chkc(i_core.chan_log[k], 3'h2);
    chkc(i_core.chan_log[k + 5'h1], 3'h1);
    k = i_core.n_conv;
    ext_trig_pin <= 1'b1;
    wait_conv(k + 5'h1);
    chkc(i_core.chan_log[k], 3'h3);
    rdc(SQR_OFF_COUNT + 12'hc, 32'h1);
    ext_trig_pin <= 1'b0;
    lat <= 4'h0;
    k = i_core.n_conv;
    wr(SQR_OFF_TRIG, 32'hc6e8);
    wait_conv(k + 5'h3);
    rdc(SQR_OFF_FLAGS, 32'h8);
    wr(SQR_OFF_CTRL, 32'h14);
    repeat (10) @(posedge pclk);
    k = i_core.n_conv;
    timer_pulse();
    wait_conv(k + 5'h2);
    repeat (20) @(posedge pclk);
    chk({27'h0, i_core.n_conv}, {27'h0, k + 5'h2});
    rdc(SQR_OFF_COUNT + 12'h8, 32'h2);
    rdc(SQR_OFF_FIFO + 12'h8, res(3'h2, 1'b0));
    rdc(SQR_OFF_FIFO + 12'h8, res(3'h2, 1'b0));
    rdc(SQR_OFF_FIFO + 12'hc, 32'haa3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(SQR_OFF_CTRL, 32'h0);
    rdc(SQR_OFF_FLAGS, 32'h0);
    rdc(SQR_OFF_STATUS, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
